// ===== include/trf_map.svh
// Register offsets, field positions and reset values of the thermal readout block
`ifndef TRF_MAP_SVH
`define TRF_MAP_SVH
`define TRF_OFF_REMOTE_ONE  8'h25
`define TRF_OFF_INTERNAL    8'h26
`define TRF_OFF_REMOTE_TWO  8'h27
`define TRF_OFF_RUN_CTRL    8'h40
`define TRF_OFF_LIMIT_STS   8'h41
`define TRF_OFF_FAULT_STS   8'h42
`define TRF_OFF_LIMIT_BASE  8'h43
`define TRF_OFF_TACH_MIN_LO 8'h54
`define TRF_OFF_TACH_MIN_HI 8'h5B
`define TRF_OFF_PWM_CFG_LO  8'h5C
`define TRF_OFF_PWM_CFG_HI  8'h5E
`define TRF_OFF_ZONE_LO     8'h5F
`define TRF_OFF_ZONE_HI     8'h61
`define TRF_OFF_RAMP_LO     8'h62
`define TRF_OFF_RAMP_HI     8'h63
`define TRF_OFF_MIND_LO     8'h64
`define TRF_OFF_MIND_HI     8'h66
`define TRF_OFF_ZLOW_LO     8'h67
`define TRF_OFF_ZLOW_HI     8'h69
`define TRF_OFF_ZABS_LO     8'h6A
`define TRF_OFF_ZABS_HI     8'h6C
`define TRF_OFF_TACH_PAIR   8'h81
`define TRF_OFF_TOPT_LO     8'h90
`define TRF_OFF_TOPT_HI     8'h92
`define TRF_OFF_POPT_LO     8'h94
`define TRF_OFF_POPT_HI     8'h96
`define TRF_OFF_TACH_MODE   8'hAB
`define TRF_OFF_TOP_R1      8'hAE
`define TRF_OFF_TOP_R2      8'hAF
`define TRF_OFF_TOP_AMB     8'hB3
`define TRF_OFF_MADJ_LO     8'hB4
`define TRF_OFF_MADJ_HI     8'hB7
`define TRF_OFF_TRIP_R1     8'hC4
`define TRF_OFF_TRIP_R2     8'hC5
`define TRF_OFF_TACH_BASE   8'hC8
`define TRF_BIT_START       0
`define TRF_BIT_LOCK        1
`define TRF_BIT_SLOW        0
`define TRF_BIT_LIM_R1      1
`define TRF_BIT_LIM_AMB     2
`define TRF_BIT_LIM_R2      3
`define TRF_BIT_FLT_R1      1
`define TRF_BIT_FLT_R2      2
`define TRF_SENSOR_ERROR    8'h80
`define TRF_TACH_SLOW       16'hFFFE
`define TRF_TACH_STALL      16'hFFFF
`define TRF_RST_PWM_CFG     8'h62
`define TRF_RST_LOW_LIMIT   8'h81
`define TRF_RST_HIGH_LIMIT  8'h7F
`define TRF_RST_ZONE_LOW    8'h5A
`define TRF_RST_TOP_TEMP    8'h64
`define TRF_MODE_FULL       3'h3
`define TRF_MODE_MANUAL     3'h7
`endif

// ===== include/trf_pkg.sv
// Types shared by the thermal readout block
package trf_pkg;
    typedef struct packed {
        logic       valid;
        logic       fault;
        logic [7:0] value;
    } trf_sample_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } trf_bus_type;

    typedef struct packed {
        logic [2:0] mode;
        logic [4:0] rest;
    } trf_pwm_cfg_type;
endpackage

// ===== design/trf_thermal_readout.sv
// Temperature readout, limit and fault status, and fan setup gating
// Functional notes
// - First remote diode reading lives at 25h.
// - Second remote diode reading lives at 27h.
// - Internal sensor reading lives at 26h, beside the remote ones.
// - Remote limit violation sets that diode's flag in limit status.
// - Both remote limit flags sit in the status register at 41h.
// - Fault status at 42h has one short/open bit per remote diode.
// - Diode connection is checked before a remote result updates.
// - Shorted or open diode loads 80h into its reading.
// - Loading 80h also sets that diode's limit flag.
// - Readings are 8-bit two's complement, 81h..7Fh, 80h means error.
// - Zone 1 first remote, zone 2 internal, zone 3 second remote.
// - Three PWM outputs and three tach inputs, manual or automatic.
// - Power up restores defaults, all PWMs full speed until start.
// - Monitoring begins only once start bit at 40h is one.
// - Automatic mode written to PWM config waits for start.
// - Before start defaults are used; afterwards programmed values.
// - Start bit 0, lock bit 1; lock protects limits and parameters.
// - Main power good resets top-temperature and zone low limits.
// - Ramp registers stay writable after start while lock is clear.
// - Slow option reports slow fan FFFEh and stalled fan FFFFh.
// - While start is clear all PWM outputs are held high.
// - Start bit writes are ignored while lock is set.
`include "trf_map.svh"
module trf_thermal_readout
    import trf_pkg::*;
#(
    parameter int NUM_FANS = 3
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           main_power_good_i,
    input  wire trf_bus_type    bus_i,
    output logic [7:0]          rdata_o,
    input  wire trf_sample_type remote_one_i,
    input  wire trf_sample_type internal_i,
    input  wire trf_sample_type remote_two_i,
    input  wire logic [2:0]     fan_speed_inputs_i,
    input  wire logic [2:0]     fan_slow_i,
    input  wire logic [2:0]     fan_stall_i,
    input  wire logic [47:0]    fan_count_i,
    input  wire logic [7:0]     duty_one_i,
    input  wire logic [7:0]     duty_two_i,
    input  wire logic [7:0]     duty_three_i,
    output logic [2:0]          pwm_full_o,
    output logic [2:0]          pwm_auto_o,
    output logic [23:0]         zone_temp_o,
    output logic                monitor_on_o
);
    if (NUM_FANS != 3) begin : g_chk
        $error("trf_thermal_readout serves exactly three fans");
    end

    function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic out_lim(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi);
        return ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
    endfunction

    // Register storage
    logic [7:0] rd1_r, rint_r, rd2_r;
    logic [7:0] run_r, lim_sts_r, flt_sts_r;
    logic [7:0] lim_r [0:5];
    logic [7:0] param_r [0:255];
    logic       pg_d_r;

    // Decode
    logic [7:0] a;
    logic       wr, rd;
    assign a  = bus_i.addr;
    assign wr = bus_i.wr;
    assign rd = bus_i.rd;

    wire logic start   = run_r[`TRF_BIT_START];
    wire logic locked  = run_r[`TRF_BIT_LOCK];
    wire logic is_ramp = in_rng(a, `TRF_OFF_RAMP_LO, `TRF_OFF_RAMP_HI);
    wire logic is_lim  = in_rng(a, `TRF_OFF_LIMIT_BASE, `TRF_OFF_LIMIT_BASE + 8'h05);
    wire logic is_param = in_rng(a, `TRF_OFF_TACH_MIN_LO, `TRF_OFF_ZABS_HI)
                       || (a == `TRF_OFF_TACH_PAIR)
                       || in_rng(a, `TRF_OFF_TOPT_LO, `TRF_OFF_TOPT_HI)
                       || in_rng(a, `TRF_OFF_POPT_LO, `TRF_OFF_POPT_HI)
                       || (a == `TRF_OFF_TACH_MODE)
                       || (a == `TRF_OFF_TOP_R1) || (a == `TRF_OFF_TOP_R2)
                       || (a == `TRF_OFF_TOP_AMB)
                       || in_rng(a, `TRF_OFF_MADJ_LO, `TRF_OFF_MADJ_HI)
                       || (a == `TRF_OFF_TRIP_R1) || (a == `TRF_OFF_TRIP_R2);
    // Lock protects everything, ramp included once locked
    wire logic param_we = wr && is_param && !locked;
    wire logic lim_we   = wr && is_lim && !locked;
    wire logic run_we   = wr && (a == `TRF_OFF_RUN_CTRL);
    wire logic pg_rise  = main_power_good_i && !pg_d_r;

    // Conversion update: fault forces the error code
    wire logic upd1 = start && remote_one_i.valid;
    wire logic upd2 = start && remote_two_i.valid;
    wire logic updi = start && internal_i.valid;
    wire logic [7:0] v1 = remote_one_i.fault ? `TRF_SENSOR_ERROR
                                             : remote_one_i.value;
    wire logic [7:0] v2 = remote_two_i.fault ? `TRF_SENSOR_ERROR
                                             : remote_two_i.value;
    // 80h sits below every legal low limit, so the flag follows
    wire logic viol1 = upd1 &&
                       (remote_one_i.fault || out_lim(v1, lim_r[0], lim_r[1]));
    wire logic violi = updi && out_lim(internal_i.value, lim_r[2], lim_r[3]);
    wire logic viol2 = upd2 &&
                       (remote_two_i.fault || out_lim(v2, lim_r[4], lim_r[5]));

    // Status set terms, one limit bit per sensor, one fault bit per remote diode
    wire logic [7:0] lim_set = ({7'h00, viol1} << `TRF_BIT_LIM_R1)
                             | ({7'h00, violi} << `TRF_BIT_LIM_AMB)
                             | ({7'h00, viol2} << `TRF_BIT_LIM_R2);
    wire logic flt1 = upd1 && remote_one_i.fault;
    wire logic flt2 = upd2 && remote_two_i.fault;
    wire logic [7:0] flt_set = ({7'h00, flt1} << `TRF_BIT_FLT_R1)
                             | ({7'h00, flt2} << `TRF_BIT_FLT_R2);
    wire logic rd_lim = rd && (a == `TRF_OFF_LIMIT_STS);
    wire logic rd_flt = rd && (a == `TRF_OFF_FAULT_STS);

    // Run control, start ignored while locked, lock sticks
    wire logic start_nxt = locked ? start : bus_i.wdata[`TRF_BIT_START];
    wire logic lock_nxt  = locked | bus_i.wdata[`TRF_BIT_LOCK];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r     <= 8'h00;
            lim_sts_r <= 8'h00;
            flt_sts_r <= 8'h00;
            rd1_r     <= 8'h00;
            rint_r    <= 8'h00;
            rd2_r     <= 8'h00;
            pg_d_r    <= 1'b1; // High, so a level already up is no edge
        end else begin
            pg_d_r <= main_power_good_i;
            if (run_we) begin
                run_r <= {6'h00, lock_nxt, start_nxt};
            end
            if (upd1) begin
                rd1_r <= v1;
            end
            if (updi) begin
                rint_r <= internal_i.value;
            end
            if (upd2) begin
                rd2_r <= v2;
            end
            // Set wins over read-clear
            lim_sts_r <= (rd_lim ? 8'h00 : lim_sts_r) | lim_set;
            flt_sts_r <= (rd_flt ? 8'h00 : flt_sts_r) | flt_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 6; i++) begin
                lim_r[i] <= i[0] ? `TRF_RST_HIGH_LIMIT : `TRF_RST_LOW_LIMIT;
            end
        end else if (lim_we) begin
            lim_r[3'(a - `TRF_OFF_LIMIT_BASE)] <= bus_i.wdata;
        end
    end

    function automatic logic [7:0] param_dflt(input logic [7:0] ad);
        if (in_rng(ad, `TRF_OFF_PWM_CFG_LO, `TRF_OFF_PWM_CFG_HI)) begin
            return `TRF_RST_PWM_CFG;
        end else if (in_rng(ad, `TRF_OFF_ZLOW_LO, `TRF_OFF_ZLOW_HI)) begin
            return `TRF_RST_ZONE_LOW;
        end else if ((ad == `TRF_OFF_TOP_R1) || (ad == `TRF_OFF_TOP_R2)
                     || (ad == `TRF_OFF_TOP_AMB)) begin
            return `TRF_RST_TOP_TEMP;
        end
        return 8'h00;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 256; i++) begin
                param_r[i] <= param_dflt(8'(i));
            end
        end else if (pg_rise) begin
            for (int i = 0; i < 256; i++) begin
                if (top_dflt_slot(8'(i))) begin
                    param_r[i] <= param_dflt(8'(i));
                end
            end
        end else if (param_we) begin
            param_r[a] <= bus_i.wdata;
        end
    end

    function automatic logic top_dflt_slot(input logic [7:0] ad);
        return (ad == `TRF_OFF_TOP_R1) || (ad == `TRF_OFF_TOP_R2)
            || (ad == `TRF_OFF_TOP_AMB) || in_rng(ad, `TRF_OFF_ZLOW_LO, `TRF_OFF_ZLOW_HI);
    endfunction

    // Effective PWM config: defaults until start
    logic [2:0] mode [0:2];
    logic [2:0] full_nxt, auto_nxt;
    always_comb begin
        full_nxt = 3'h0;
        auto_nxt = 3'h0;
        for (int f = 0; f < 3; f++) begin
            mode[f] = start ? param_r[`TRF_OFF_PWM_CFG_LO + 8'(f)][7:5]
                            : `TRF_MODE_FULL;
            full_nxt[f] = !start || (mode[f] == `TRF_MODE_FULL);
            auto_nxt[f] = start && (mode[f] <= 3'h2 || mode[f] == 3'h5
                                    || mode[f] == 3'h6);
        end
    end

    // Tach reading with slow and stall codes
    function automatic logic [15:0] tach_val(input int f);
        if (param_r[`TRF_OFF_TOPT_LO + 8'(f)][`TRF_BIT_SLOW] && fan_stall_i[f]) begin
            return `TRF_TACH_STALL;
        end else if (param_r[`TRF_OFF_TOPT_LO + 8'(f)][`TRF_BIT_SLOW] && fan_slow_i[f]) begin
            return `TRF_TACH_SLOW;
        end
        return fan_count_i[16*f +: 16];
    endfunction

    // Read mux
    logic [7:0] rdata_nxt;
    logic [2:0] tidx;
    logic [15:0] tv;
    always_comb begin
        tidx = 3'(a - `TRF_OFF_TACH_BASE) >> 1;
        tv = (tidx < 3'h3) ? tach_val(int'(tidx)) : 16'h0000;
        rdata_nxt = 8'h00;
        if (a == `TRF_OFF_REMOTE_ONE) begin
            rdata_nxt = rd1_r;
        end else if (a == `TRF_OFF_INTERNAL) begin
            rdata_nxt = rint_r;
        end else if (a == `TRF_OFF_REMOTE_TWO) begin
            rdata_nxt = rd2_r;
        end else if (a == `TRF_OFF_RUN_CTRL) begin
            rdata_nxt = run_r;
        end else if (a == `TRF_OFF_LIMIT_STS) begin
            rdata_nxt = lim_sts_r;
        end else if (a == `TRF_OFF_FAULT_STS) begin
            rdata_nxt = flt_sts_r;
        end else if (is_lim) begin
            rdata_nxt = lim_r[3'(a - `TRF_OFF_LIMIT_BASE)];
        end else if (is_param) begin
            rdata_nxt = param_r[a];
        end else if (in_rng(a, `TRF_OFF_TACH_BASE, `TRF_OFF_TACH_BASE + 8'h05)) begin
            rdata_nxt = a[0] ? tv[15:8] : tv[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o      <= 8'h00;
            pwm_full_o   <= 3'h7;
            pwm_auto_o   <= 3'h0;
            zone_temp_o  <= 24'h000000;
            monitor_on_o <= 1'b0;
        end else begin
            rdata_o      <= rd ? rdata_nxt : 8'h00;
            pwm_full_o   <= full_nxt;
            pwm_auto_o   <= auto_nxt;
            zone_temp_o  <= {rd2_r, rint_r, rd1_r};
            monitor_on_o <= start;
        end
    end

    // Checks
    property p_fault_code;
        @(posedge clk_i) disable iff (rst_i)
        upd1 && remote_one_i.fault |=> rd1_r == `TRF_SENSOR_ERROR;
    endproperty
    a_fault_code: assert property (p_fault_code) else $error("fault not coded");

    property p_fault_flag;
        @(posedge clk_i) disable iff (rst_i)
        upd2 && remote_two_i.fault |=> lim_sts_r[`TRF_BIT_LIM_R2] && flt_sts_r[`TRF_BIT_FLT_R2];
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag missing");

    property p_no_start_hold;
        @(posedge clk_i) disable iff (rst_i)
        !start |=> rd1_r == $past(rd1_r);
    endproperty
    a_no_start_hold: assert property (p_no_start_hold) else $error("updated asleep");

    property p_sleep_full;
        @(posedge clk_i) disable iff (rst_i)
        !start ##1 !start |-> pwm_full_o == 3'h7;
    endproperty
    a_sleep_full: assert property (p_sleep_full) else $error("sleep not full");

    property p_lock_start;
        @(posedge clk_i) disable iff (rst_i)
        locked |=> locked && start == $past(start);
    endproperty
    a_lock_start: assert property (p_lock_start) else $error("locked start moved");

    property p_lock_ramp;
        @(posedge clk_i) disable iff (rst_i)
        locked && wr && is_ramp
            |=> $stable(param_r[`TRF_OFF_RAMP_LO]) && $stable(param_r[`TRF_OFF_RAMP_HI]);
    endproperty
    a_lock_ramp: assert property (p_lock_ramp) else $error("locked ramp written");

    property p_limit_viol;
        @(posedge clk_i) disable iff (rst_i)
        viol1 |=> lim_sts_r[`TRF_BIT_LIM_R1] [*1] ##0 rd1_r == $past(v1);
    endproperty
    a_limit_viol: assert property (p_limit_viol) else $error("limit flag missing");

    property p_pg_default;
        @(posedge clk_i) disable iff (rst_i)
        pg_rise |=> param_r[`TRF_OFF_TOP_R1] == `TRF_RST_TOP_TEMP;
    endproperty
    a_pg_default: assert property (p_pg_default) else $error("top temp not reset");

    property p_fault_status;
        @(posedge clk_i) disable iff (rst_i)
        flt1 |=> flt_sts_r[`TRF_BIT_FLT_R1] && lim_sts_r[`TRF_BIT_LIM_R1];
    endproperty
    a_fault_status: assert property (p_fault_status) else $error("no fault bit");

    property p_lock_limits;
        @(posedge clk_i) disable iff (rst_i)
        locked |=> $stable(lim_r[0]) && $stable(lim_r[1]) && $stable(lim_r[5]);
    endproperty
    a_lock_limits: assert property (p_lock_limits) else $error("locked limit moved");

    property p_sleep_manual;
        @(posedge clk_i) disable iff (rst_i)
        !start |=> pwm_auto_o == 3'h0;
    endproperty
    a_sleep_manual: assert property (p_sleep_manual) else $error("auto asleep");

    property p_monitor_off;
        @(posedge clk_i) disable iff (rst_i)
        !start |=> !monitor_on_o;
    endproperty
    a_monitor_off: assert property (p_monitor_off) else $error("monitor on asleep");
endmodule

// ===== test/trf_diode_model.sv
// Behavioural remote diode and converter feeding one sample port
module trf_diode_model
    import trf_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     conv_i,
    input  wire logic [7:0] temp_i,
    input  wire logic     fault_i,
    output trf_sample_type  sample_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sample_o = '0;
    // Value is only good on the done pulse; between pulses it toggles
    always @(posedge clk_i) begin
        sample_o.valid <= conv_i;
        if (conv_i) begin
            sample_o.fault <= fault_i;
            sample_o.value <= fault_i ? 8'hA5 : temp_i;
        end else begin
            sample_o.fault <= ~sample_o.fault;
            sample_o.value <= ~sample_o.value;
        end
    end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the thermal readout block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import trf_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic mpg = 1;
    trf_bus_type bus_i = '0;
    logic [7:0] rdata_o;
    trf_sample_type s1, si, s2;
    logic [2:0] conv = 0;
    logic [7:0] t1 = 0, ti = 0, t2 = 0;
    logic [2:0] flt = 0, slow = 0, stall = 0;
    logic [2:0] pwm_full_o, pwm_auto_o;
    logic [23:0] zone_temp_o;
    logic monitor_on_o;
    int failures = 0;
    int check_count = 0;

    initial forever #10 clk_i = ~clk_i;

    trf_diode_model M1 (.clk_i(clk_i), .conv_i(conv[0]), .temp_i(t1), .fault_i(flt[0]),
                        .sample_o(s1));
    trf_diode_model MI (.clk_i(clk_i), .conv_i(conv[1]), .temp_i(ti), .fault_i(1'b0),
                        .sample_o(si));
    trf_diode_model M2 (.clk_i(clk_i), .conv_i(conv[2]), .temp_i(t2), .fault_i(flt[2]),
                        .sample_o(s2));

    trf_thermal_readout DUT (
        .clk_i(clk_i), .rst_i(rst_i), .main_power_good_i(mpg), .bus_i(bus_i),
        .rdata_o(rdata_o), .remote_one_i(s1), .internal_i(si), .remote_two_i(s2),
        .fan_speed_inputs_i(3'h0), .fan_slow_i(slow), .fan_stall_i(stall),
        .fan_count_i({16'h1234, 16'h5555, 16'h5555}),
        .duty_one_i(8'h00), .duty_two_i(8'h00), .duty_three_i(8'h00),
        .pwm_full_o(pwm_full_o), .pwm_auto_o(pwm_auto_o), .zone_temp_o(zone_temp_o),
        .monitor_on_o(monitor_on_o));

    task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 chk({16'h0, rdata_o}, {16'h0, exp}, "read");
    endtask

    task cnv(input logic [2:0] w, input logic [7:0] a, b, c, input logic [2:0] f);
        @(posedge clk_i);
        conv <= w;
        t1 <= a;
        ti <= b;
        t2 <= c;
        flt <= f;
        @(posedge clk_i);
        conv <= 3'h0;
        repeat (3) @(posedge clk_i);
    endtask

    task t_reset;
        chk({21'h0, pwm_full_o}, 24'h7, "full at reset");
        chk({21'h0, pwm_auto_o}, 24'h0, "auto at reset");
        rd_chk(8'h43, 8'h81);
        rd_chk(8'h44, 8'h7F);
        rd_chk(8'h5C, 8'h62);
        rd_chk(8'hF0, 8'h00);
        $display("test reset done");
    endtask

    task t_sleep;
        wr(8'h5C, 8'h02);
        wr(8'h62, 8'h01);
        cnv(3'h7, 8'h19, 8'hCE, 8'h7F, 3'h0);
        chk(zone_temp_o, 24'h0, "no update asleep");
        chk({21'h0, pwm_auto_o}, 24'h0, "auto waits");
        chk({21'h0, pwm_full_o}, 24'h7, "full asleep");
        wr(8'h40, 8'h01);
        repeat (2) @(posedge clk_i);
        chk({23'h0, monitor_on_o}, 24'h1, "started");
        chk({21'h0, pwm_auto_o}, 24'h1, "auto after start");
        $display("test sleep done");
    endtask

    task t_read;
        cnv(3'h7, 8'h19, 8'hCE, 8'h7F, 3'h0);
        rd_chk(8'h25, 8'h19);
        rd_chk(8'h26, 8'hCE);
        rd_chk(8'h27, 8'h7F);
        chk(zone_temp_o, 24'h7FCE19, "zones");
        cnv(3'h1, 8'h81, 8'h00, 8'h00, 3'h0);
        rd_chk(8'h41, 8'h00);
        wr(8'h44, 8'h18);
        cnv(3'h1, 8'h19, 8'h00, 8'h00, 3'h0);
        rd_chk(8'h41, 8'h02);
        rd_chk(8'h41, 8'h00);
        $display("test read done");
    endtask

    task t_fault;
        cnv(3'h5, 8'h10, 8'h00, 8'h10, 3'h5);
        rd_chk(8'h25, 8'h80);
        rd_chk(8'h27, 8'h80);
        rd_chk(8'h41, 8'h0A);
        rd_chk(8'h42, 8'h06);
        $display("test fault done");
    endtask

    task t_tach;
        wr(8'h90, 8'h01);
        wr(8'h91, 8'h01);
        slow <= 3'h1;
        stall <= 3'h2;
        rd_chk(8'hC8, 8'hFE);
        rd_chk(8'hC9, 8'hFF);
        rd_chk(8'hCA, 8'hFF);
        rd_chk(8'hCB, 8'hFF);
        rd_chk(8'hCC, 8'h34);
        rd_chk(8'hCD, 8'h12);
        $display("test tach done");
    endtask

    task t_power;
        wr(8'hAE, 8'h20);
        wr(8'h67, 8'h30);
        mpg <= 1'b0;
        @(posedge clk_i);
        mpg <= 1'b1;
        repeat (2) @(posedge clk_i);
        rd_chk(8'hAE, 8'h64);
        rd_chk(8'h67, 8'h5A);
        wr(8'h62, 8'h00);
        wr(8'h40, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({21'h0, pwm_full_o}, 24'h7, "full stopped");
        wr(8'hAE, 8'h20);
        wr(8'h67, 8'h30);
        wr(8'h40, 8'h01);
        wr(8'h5D, 8'hA0);
        wr(8'h5E, 8'hE0);
        repeat (2) @(posedge clk_i);
        #1 chk({21'h0, pwm_auto_o}, 24'h3, "auto and hottest");
        chk({21'h0, pwm_full_o}, 24'h0, "manual not full");
        rd_chk(8'hAE, 8'h20);
        wr(8'h62, 8'h05);
        rd_chk(8'h62, 8'h05);
        $display("test power done");
    endtask

    task t_lock;
        wr(8'h40, 8'h03);
        wr(8'h43, 8'h00);
        rd_chk(8'h43, 8'h81);
        wr(8'h62, 8'h07);
        rd_chk(8'h62, 8'h05);
        wr(8'h5C, 8'hE0);
        wr(8'h40, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({23'h0, monitor_on_o}, 24'h1, "start held");
        chk({21'h0, pwm_auto_o}, 24'h3, "mode held");
        $display("test lock done");
    endtask

    task end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset();
        t_sleep();
        t_read();
        t_fault();
        t_tach();
        t_power();
        t_lock();
        end_sim();
    end

    // Whole run is about 135 cycles; this is ample margin
    initial begin
        #100000;
        failures++;
        end_sim();
    end
endmodule
